// ### design/slb_latch_bank.sv
// programming latch bank with power and band selection sequencing
// Rules for this block and its host
// R01: select 00 loads general settings latch
// R02: select 10 loads feedback divider latch
// R03: select 01 loads reference divider latch
// R04: host orders reference, general, then feedback
// R05: first general write powers up, bias starts settling
// R06: host waits settle interval before feedback
// R07: chip enable restore keeps band if unchanged
// R08: software powerup keeps band if unchanged
// R09: host never rewrites feedback while down
// R10: shift msb first, copy on strobe rise
// R11: feedback write while powered up runs five-cycle band selection
// R12: host avoids test select and test bit
// R13: host counts its own settle interval
module slb_latch_bank
   import slb_pkg::*;
(
   input  wire logic        clock,                   // system clock, 100 MHz
   input  wire logic        sys_rst,                 // synchronous reset, active high
   input  wire logic        serial_clk,              // serial link clock
   input  wire logic        serial_data,             // serial link data
   input  wire logic        latch_strobe,            // latch strobe
   input  wire logic        chip_enable,             // hardware enable, low powers down
   input  wire logic        pfd_tick,                // one pulse per detector cycle
   output logic [23:0]      general_settings_latch,  // general settings contents
   output logic [23:0]      feedback_divider_latch,  // feedback divider contents
   output logic [23:0]      reference_divider_latch, // reference divider contents
   output logic             pump_gain_select,        // latest pump gain bit
   output logic             powered_down,            // core is powered down
   output logic             bias_settling,           // bias settling after first powerup
   output logic             band_select_active,      // band selection running
   output logic             band_retained,           // stored band still valid
   output logic             counter_hold             // counters held in load state
);

   // ****************************************
   // declarations
   // ****************************************
   logic [23:0] load_word;      // captured shift word
   logic        load_pulse;     // word capture strobe
   slb_power_t  power_state;    // current power state
   slb_power_t  next_power;     // next power state
   logic [1:0]  sync_cnt;       // sync powerdown edge countdown
   logic        sync_armed;     // sync powerdown pending
   logic [2:0]  band_cnt;       // remaining band selection cycles
   logic [2:0]  band_div_cnt;   // band clock prescale count
   logic [2:0]  band_div_limit; // band clock prescale terminal value
   logic        band_tick;      // one band selection clock
   logic        gs_load;        // general settings write
   logic        fb_load;        // feedback divider write
   logic        rd_load;        // reference divider write

   // serial front end
   slb_shift_in u_shift_in (
      .clock        (clock),
      .sys_rst      (sys_rst),
      .serial_clk   (serial_clk),
      .serial_data  (serial_data),
      .latch_strobe (latch_strobe),
      .load_word    (load_word),
      .load_pulse   (load_pulse)
   );

   // ****************************************
   // latch decode
   // ****************************************
   always_comb begin
      gs_load = load_pulse && (load_word[1:0] == SEL_GENERAL);   // R01
      fb_load = load_pulse && (load_word[1:0] == SEL_FEEDBACK);  // R02
      rd_load = load_pulse && (load_word[1:0] == SEL_REFERENCE); // R03
   end

   // latch storage, test select is dropped
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         general_settings_latch  <= LATCH_RESET;
         feedback_divider_latch  <= LATCH_RESET;
         reference_divider_latch <= LATCH_RESET;
      end else begin
         if (gs_load) begin
            general_settings_latch <= load_word; // R01
         end
         if (fb_load) begin
            feedback_divider_latch <= load_word; // R02
         end
         if (rd_load) begin
            reference_divider_latch <= load_word; // R03
         end
      end
   end

   // pump gain follows whichever of general and feedback latch wrote last
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         pump_gain_select <= 1'b0;
      end else if (gs_load) begin
         pump_gain_select <= load_word[GS_PUMP_GAIN];
      end else if (fb_load) begin
         pump_gain_select <= load_word[FB_PUMP_GAIN];
      end
   end

   // ****************************************
   // power sequencing
   // ****************************************
   // sync powerdown waits two detector edges after the strobe
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         sync_armed <= 1'b0;
         sync_cnt   <= 2'h0;
      end else if (gs_load) begin
         sync_armed <= load_word[GS_PD_REQUEST] && load_word[GS_PD_SYNC];
         sync_cnt   <= SYNC_PD_EDGES;
      end else if (sync_armed && pfd_tick) begin
         sync_cnt   <= sync_cnt - 2'h1;
         sync_armed <= (sync_cnt != 2'h1);
      end
   end

   // next power state
   always_comb begin
      next_power = power_state;
      unique case (power_state)
         PWR_UNPROGRAMMED: begin
            // first general write without request powers up
            if (gs_load && chip_enable && !load_word[GS_PD_REQUEST]) begin
               next_power = PWR_ACTIVE; // R05
            end
         end
         PWR_ACTIVE: begin
            if (!chip_enable) begin
               next_power = PWR_DOWN; // R07
            end else if (gs_load && load_word[GS_PD_REQUEST] && !load_word[GS_PD_SYNC]) begin
               next_power = PWR_DOWN;
            end else if (sync_armed && pfd_tick && sync_cnt == 2'h1) begin
               next_power = PWR_DOWN;
            end
         end
         PWR_DOWN: begin
            // leave when enabled and no request stands
            if (chip_enable && !sync_armed && !(gs_load ? load_word[GS_PD_REQUEST]
                                               : general_settings_latch[GS_PD_REQUEST])) begin
               next_power = PWR_ACTIVE; // R08
            end
         end
         default: begin
            next_power = PWR_DOWN;
         end
      endcase
   end

   // power state and its flags
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         power_state  <= PWR_UNPROGRAMMED;
         powered_down <= 1'b1;
         counter_hold <= 1'b1;
      end else begin
         power_state  <= next_power;
         powered_down <= (next_power != PWR_ACTIVE);
         counter_hold <= (next_power != PWR_ACTIVE) ||
                         (gs_load ? load_word[GS_COUNTER_CLEAR] : general_settings_latch[GS_COUNTER_CLEAR]);
      end
   end

   // bias settles from first powerup until the feedback write or a powerdown
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         bias_settling <= 1'b0;
      end else if (power_state == PWR_UNPROGRAMMED && next_power == PWR_ACTIVE) begin
         bias_settling <= 1'b1; // R05
      end else if (fb_load || next_power != PWR_ACTIVE) begin
         bias_settling <= 1'b0;
      end
   end

   // ****************************************
   // band selection
   // ****************************************
   always_comb begin
      band_div_limit = 3'((4'h1 << reference_divider_latch[RD_BAND_DIV +: 2]) - 4'h1);
      band_tick      = pfd_tick && band_select_active && (band_div_cnt == band_div_limit);
   end

   // five band clocks per selection, aborted by powerdown
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         band_cnt           <= 3'h0;
         band_div_cnt       <= 3'h0;
         band_select_active <= 1'b0;
      end else if (next_power != PWR_ACTIVE) begin
         band_cnt           <= 3'h0;
         band_div_cnt       <= 3'h0;
         band_select_active <= 1'b0;
      end else if (fb_load) begin
         band_cnt           <= BAND_CYCLES; // R11
         band_div_cnt       <= 3'h0;
         band_select_active <= 1'b1;
      end else if (band_select_active && pfd_tick) begin
         band_div_cnt <= band_tick ? 3'h0 : band_div_cnt + 3'h1;
         if (band_tick) begin
            band_cnt           <= band_cnt - 3'h1; // R11
            band_select_active <= (band_cnt != 3'h1);
         end
      end
   end

   // band stays valid across powerdown unless feedback was rewritten or its selection was aborted by the powerdown
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         band_retained <= 1'b0;
      end else if (fb_load) begin
         band_retained <= (power_state == PWR_ACTIVE) && (next_power == PWR_ACTIVE); // R07 R08 R09
      end else if (band_select_active && next_power != PWR_ACTIVE) begin
         band_retained <= 1'b0;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   logic [3:0] band_ticks_seen; // band clocks during current selection
   always_ff @(posedge clock) begin
      if (sys_rst || fb_load) begin
         band_ticks_seen <= 4'h0;
      end else if (band_tick) begin
         band_ticks_seen <= band_ticks_seen + 4'h1;
      end
   end

   sequence gs_write_s;
      load_pulse && load_word[1:0] == SEL_GENERAL;
   endsequence

   sequence fb_write_on_s;
      load_pulse && load_word[1:0] == SEL_FEEDBACK && power_state == PWR_ACTIVE && next_power == PWR_ACTIVE;
   endsequence

   general_load_a: assert property (gs_write_s |=> general_settings_latch == $past(load_word)) // R01
      else $error("general settings latch not loaded");

   feedback_load_a: assert property (load_pulse && load_word[1:0] == SEL_FEEDBACK
                                     |=> feedback_divider_latch == $past(load_word)) // R02
      else $error("feedback divider latch not loaded");

   reference_load_a: assert property (load_pulse && load_word[1:0] == SEL_REFERENCE
                                      |=> reference_divider_latch == $past(load_word)) // R03
      else $error("reference divider latch not loaded");

   test_ignore_a: assert property (load_pulse && load_word[1:0] == SEL_TEST
                                   |=> $stable(general_settings_latch) && $stable(feedback_divider_latch)
                                       && $stable(reference_divider_latch)) // R12
      else $error("test select changed a latch");

   first_powerup_a: assert property (power_state == PWR_UNPROGRAMMED and gs_write_s
                                     and chip_enable && !load_word[GS_PD_REQUEST]
                                     |=> !powered_down && bias_settling) // R05
      else $error("general write did not power up");

   band_start_a: assert property (fb_write_on_s |=> band_select_active && !bias_settling) // R11
      else $error("feedback write did not start band selection");

   band_length_a: assert property ($fell(band_select_active) && !powered_down |-> band_ticks_seen == 4'h5) // R11
      else $error("band selection length wrong");

   // a low sample forces powerdown and stops band and bias activity at the next edge
   enable_down_a: assert property (!chip_enable |=> powered_down && !band_select_active && !bias_settling) // R07
      else $error("chip enable low did not power down");

   band_keep_a: assert property ($fell(powered_down) && band_retained |=> !band_select_active) // R08
      else $error("retained band reselected after powerup");

   gain_latest_a: assert property (gs_write_s |=> pump_gain_select == $past(load_word[GS_PUMP_GAIN])) // R01
      else $error("pump gain not from latest write");

endmodule : slb_latch_bank

// ### design/slb_shift_in.sv
// serial shift register and strobe detector for the latch bank
module slb_shift_in
   import slb_pkg::*;
(
   input  wire logic        clock,        // system clock
   input  wire logic        sys_rst,      // synchronous reset, active high
   input  wire logic        serial_clk,   // serial link clock level
   input  wire logic        serial_data,  // serial link data
   input  wire logic        latch_strobe, // latch strobe level
   output logic [23:0]      load_word,    // word captured at strobe rise
   output logic             load_pulse    // one cycle, load_word valid
);

   logic [23:0] shift_reg;      // msb first shift chain
   logic        serial_clk_d;   // previous serial clock level
   logic        latch_strobe_d; // previous strobe level

   // ****************************************
   // edge detection
   // ****************************************
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         serial_clk_d   <= 1'b0;
         latch_strobe_d <= 1'b0;
      end else begin
         serial_clk_d   <= serial_clk;
         latch_strobe_d <= latch_strobe;
      end
   end

   // shift one bit per rising serial clock
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         shift_reg <= LATCH_RESET;
      end else if (serial_clk && !serial_clk_d) begin
         shift_reg <= {shift_reg[22:0], serial_data}; // R10
      end
   end

   // copy chain out on rising strobe
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         load_word  <= LATCH_RESET;
         load_pulse <= 1'b0;
      end else begin
         load_pulse <= latch_strobe && !latch_strobe_d; // R10
         if (latch_strobe && !latch_strobe_d) begin
            load_word <= shift_reg;
         end
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   // strobe rise yields a load one cycle later
   strobe_load_a: assert property ($rose(latch_strobe) |=> load_pulse && load_word == $past(shift_reg)) // R10
      else $error("strobe rise did not load the shift word");

endmodule : slb_shift_in

// ### include/slb_pkg.sv
// constants and types shared by the synthesizer latch bank
package slb_pkg;

   // ****************************************
   // word format
   // ****************************************
   localparam int unsigned LATCH_W          = 24;           // shift word and latch width
   localparam logic [23:0] LATCH_RESET      = 24'h000000;   // latch contents after reset
   localparam logic [1:0]  SEL_GENERAL      = 2'h0;         // select code, general settings
   localparam logic [1:0]  SEL_REFERENCE    = 2'h1;         // select code, reference divider
   localparam logic [1:0]  SEL_FEEDBACK     = 2'h2;         // select code, feedback divider
   localparam logic [1:0]  SEL_TEST         = 2'h3;         // select code, factory test latch

   // ****************************************
   // general settings field positions (lsb)
   // ****************************************
   localparam int unsigned GS_CORE_CURRENT  = 2;            // core current level, 2 bits
   localparam int unsigned GS_COUNTER_CLEAR = 4;            // counter clear
   localparam int unsigned GS_MUX_SELECT    = 5;            // mux select, 3 bits
   localparam int unsigned GS_POLARITY      = 8;            // detector polarity
   localparam int unsigned GS_TRISTATE      = 9;            // pump tristate
   localparam int unsigned GS_PUMP_GAIN     = 10;           // pump gain select
   localparam int unsigned GS_MUTE          = 11;           // mute until lock
   localparam int unsigned GS_OUT_POWER     = 12;           // output power level, 2 bits
   localparam int unsigned GS_PUMP_ONE      = 14;           // pump current one, 3 bits
   localparam int unsigned GS_PUMP_TWO      = 17;           // pump current two, 3 bits
   localparam int unsigned GS_PD_REQUEST    = 20;           // powerdown request
   localparam int unsigned GS_PD_SYNC       = 21;           // powerdown sync select
   localparam int unsigned GS_PRESCALER     = 22;           // prescaler select, 2 bits

   // ****************************************
   // feedback divider field positions (lsb)
   // ****************************************
   localparam int unsigned FB_SWALLOW       = 2;            // swallow count, 5 bits
   localparam int unsigned FB_SPARE         = 7;            // spare bit
   localparam int unsigned FB_MAIN          = 8;            // main count, 13 bits
   localparam int unsigned FB_PUMP_GAIN     = 21;           // pump gain select
   localparam int unsigned FB_HALVER        = 22;           // output halver
   localparam int unsigned FB_HALVED_FB     = 23;           // halved feedback select

   // ****************************************
   // reference divider field positions (lsb)
   // ****************************************
   localparam int unsigned RD_DIVIDER       = 2;            // divider, 14 bits
   localparam int unsigned RD_ANTIBACKLASH  = 16;           // antibacklash width, 2 bits
   localparam int unsigned RD_LOCK_PREC     = 18;           // lock count precision
   localparam int unsigned RD_TEST_BIT      = 19;           // factory test bit
   localparam int unsigned RD_BAND_DIV      = 20;           // band clock divider, 2 bits
   localparam int unsigned RD_SPARE         = 22;           // spare bits, 2 bits

   // ****************************************
   // timing counts in band clock and detector cycles
   // ****************************************
   localparam logic [2:0]  BAND_CYCLES      = 3'h5;         // band selection length
   localparam logic [1:0]  SYNC_PD_EDGES    = 2'h2;         // sync powerdown edge count

   // power state of the synthesizer core
   typedef enum logic [1:0] {
      PWR_UNPROGRAMMED = 2'b00,
      PWR_ACTIVE       = 2'b01,
      PWR_DOWN         = 2'b10
   } slb_power_t;

endpackage : slb_pkg

// ### verif/slb_host_model.sv
// host controller model driving the three-wire programming link
module slb_host_model #(
   parameter int unsigned SETTLE_CYCLES = 100  // settle wait in clocks, shortened for simulation
) (
   input  wire logic clock,        // system clock
   output logic      serial_clk,   // link clock, still low outside frames
   output logic      serial_data,  // link data
   output logic      latch_strobe  // rise copies the shift word
);
   timeunit 1ns;
   timeprecision 100ps;

   // ****************************************
   // idle link
   // ****************************************
   initial begin
      serial_clk   = 1'b0;
      serial_data  = 1'b0;
      latch_strobe = 1'b0;
   end

   // ****************************************
   // link tasks
   // ****************************************
   // shift one word msb first, clock high one cycle and low one cycle
   task automatic send_word(input logic [23:0] word);
      for (int i = 23; i >= 0; i--) begin
         @(posedge clock);
         #1;
         serial_data = word[i];
         serial_clk  = 1'b1;
         @(posedge clock);
         #1;
         serial_clk = 1'b0;
      end
      @(posedge clock);
      #1;
      serial_data  = ~word[0];  // released line shows no stale bit
      latch_strobe = 1'b1;
      repeat (2) @(posedge clock);
      #1;
      latch_strobe = 1'b0;
   endtask : send_word

   // host counts its own clocks after general settings
   task automatic settle_wait();
      repeat (SETTLE_CYCLES) @(posedge clock);
   endtask : settle_wait

   // full programming order, also used after a feedback change while down
   task automatic program_all(input logic [23:0] ref_w, input logic [23:0] gen_w, input logic [23:0] fb_w);
      send_word(ref_w);
      send_word(gen_w);
      settle_wait();
      send_word(fb_w);
   endtask : program_all
endmodule : slb_host_model

// ### verif/tb.sv
// self-checking bench for the synthesizer latch bank
module tb
   import slb_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   // ****************************************
   // constants and signals
   // ****************************************
   localparam int          TICK   = 8;            // detector cycle in clocks
   localparam logic [23:0] REF_W  = 24'h031f45;   // reference, band clock undivided, test bit clear
   localparam logic [23:0] REF2_W = 24'h131f45;   // reference, band clock halved, test bit clear
   localparam logic [23:0] GEN_W  = 24'hc8a4a8;   // general, powered up, pump gain set
   localparam logic [23:0] FB_W   = 24'h9f3a56;   // feedback, pump gain clear
   localparam logic [23:0] FB2_W  = 24'h9f3b56;   // feedback, other main count
   localparam logic [23:0] TEST_W = 24'h5a5a5b;   // factory test select
   logic        clock, sys_rst, chip_enable, pfd_tick;    // bench driven inputs
   logic        serial_clk, serial_data, latch_strobe;    // host driven link
   logic [23:0] general_settings_latch, feedback_divider_latch, reference_divider_latch;
   logic        pump_gain_select, powered_down, bias_settling;
   logic        band_select_active, band_retained, counter_hold;
   int          failures, checks_done, tick_cnt;

   // ****************************************
   // instances
   // ****************************************
   slb_latch_bank uut (.clock(clock), .sys_rst(sys_rst), .serial_clk(serial_clk), .serial_data(serial_data),
      .latch_strobe(latch_strobe), .chip_enable(chip_enable), .pfd_tick(pfd_tick),
      .general_settings_latch(general_settings_latch), .feedback_divider_latch(feedback_divider_latch),
      .reference_divider_latch(reference_divider_latch), .pump_gain_select(pump_gain_select),
      .powered_down(powered_down), .bias_settling(bias_settling), .band_select_active(band_select_active),
      .band_retained(band_retained), .counter_hold(counter_hold));
   slb_host_model #(.SETTLE_CYCLES(100)) host (.clock(clock), .serial_clk(serial_clk),
      .serial_data(serial_data), .latch_strobe(latch_strobe));

   // ****************************************
   // clock, detector ticks, watchdog
   // ****************************************
   initial clock = 1'b0;
   always #5 clock = ~clock;

   // one detector pulse every TICK clocks
   always begin
      @(posedge clock);
      #1;
      pfd_tick = (tick_cnt == TICK - 1);
      tick_cnt = (tick_cnt == TICK - 1) ? 0 : tick_cnt + 1;
   end

   // whole run needs about 1000 clocks
   initial begin
      #100000;
      failures++;
      $display("unexpected at %0t: watchdog ran out", $time);
      final_report();
   end

   // ****************************************
   // helpers
   // ****************************************
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : step

   // bounded wait for a level, n returns clocks spent
   task automatic wait_level(ref logic sig, input logic lvl, input int limit, output int n);
      n = 0;
      while (sig !== lvl && n < limit) begin
         step(1);
         n++;
      end
   endtask : wait_level

   // band selection must end after five band clocks of div detector cycles each
   task automatic band_end(input int div);
      int n;
      wait_level(band_select_active, 1'b0, 20 * TICK * div, n);
      chk(band_select_active, 1'b0);
      chk(n >= (BAND_CYCLES * div - 1) * TICK && n <= BAND_CYCLES * div * TICK, 1'b1);
      chk(band_retained, 1'b1);
   endtask : band_end

   task automatic final_report();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : final_report

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset();
      chk(general_settings_latch, LATCH_RESET);
      chk(feedback_divider_latch, LATCH_RESET);
      chk(reference_divider_latch, LATCH_RESET);
      chk(powered_down, 1'b1);
      chk(counter_hold, 1'b1);
   endtask : t_reset

   // first programming in order with settle wait
   task automatic t_powerup();
      host.send_word(REF_W);
      step(1);
      chk(reference_divider_latch, REF_W);
      chk(powered_down, 1'b1);
      host.send_word(GEN_W);
      step(1);
      chk(general_settings_latch, GEN_W);
      chk(powered_down, 1'b0);
      chk(pump_gain_select, 1'b1);
      host.settle_wait();
      chk(bias_settling, 1'b1);
      host.send_word(FB_W);
      step(1);
      chk(feedback_divider_latch, FB_W);
      chk(pump_gain_select, 1'b0);
      chk(bias_settling, 1'b0);
      chk(band_select_active, 1'b1);
      band_end(1);
   endtask : t_powerup

   // test select must leave every latch alone
   task automatic t_test_select();
      host.send_word(TEST_W);
      step(1);
      chk(general_settings_latch, GEN_W);
      chk(feedback_divider_latch, FB_W);
      chk(reference_divider_latch, REF_W);
   endtask : t_test_select

   // chip enable low and back, band kept
   task automatic t_hw_down();
      chip_enable = 1'b0;
      step(1);
      chk(powered_down, 1'b1);
      chk(counter_hold, 1'b1);
      step(20);
      chip_enable = 1'b1;
      step(2);
      chk(powered_down, 1'b0);
      chk(band_retained, 1'b1);
      chk(band_select_active, 1'b0);
   endtask : t_hw_down

   // software down, immediate then synchronous
   task automatic t_sw_down();
      int n;
      host.send_word(GEN_W | 24'h100000);
      step(1);
      chk(powered_down, 1'b1);
      host.send_word(GEN_W);
      step(1);
      chk(powered_down, 1'b0);
      chk(band_retained, 1'b1);
      chk(band_select_active, 1'b0);
      host.send_word(GEN_W | 24'h300000);
      step(1);
      chk(powered_down, 1'b0);
      wait_level(powered_down, 1'b1, 3 * TICK, n);
      chk(powered_down, 1'b1);
   endtask : t_sw_down

   // feedback changed while down loses the band until full reprogramming
   task automatic t_fb_while_down();
      host.send_word(FB2_W);
      step(1);
      chk(feedback_divider_latch, FB2_W);
      chk(band_retained, 1'b0);
      chk(band_select_active, 1'b0);
      host.program_all(REF2_W, GEN_W, FB2_W);
      step(1);
      chk(reference_divider_latch, REF2_W);
      chk(powered_down, 1'b0);
      chk(band_select_active, 1'b1);
      band_end(2);
   endtask : t_fb_while_down

   // counter clear holds counters, pump gain follows latest write
   task automatic t_counter_clear();
      host.send_word(GEN_W | 24'h000010);
      step(1);
      chk(counter_hold, 1'b1);
      chk(pump_gain_select, 1'b1);
      host.send_word(GEN_W);
      step(1);
      chk(counter_hold, 1'b0);
   endtask : t_counter_clear

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      sys_rst     = 1'b1;
      chip_enable = 1'b1;
      pfd_tick    = 1'b0;
      tick_cnt    = 0;
      failures    = 0;
      checks_done = 0;
      repeat (5) @(posedge clock);
      #1;
      sys_rst = 1'b0;
      t_reset();
      t_powerup();
      t_test_select();
      t_hw_down();
      t_sw_down();
      t_fb_while_down();
      t_counter_clear();
      final_report();
   end
endmodule : tb
